// ===== dtec_pkg.sv
// Shared constants, types and register map of the dual timer/event counter.
`default_nettype none

package dtec_pkg;

  // Register locations on the plain register port.
  localparam logic [7:0] ADDR_C0_DATA = 8'h0d;
  localparam logic [7:0] ADDR_C0_CTRL = 8'h0e;
  localparam logic [7:0] ADDR_C1_HIGH = 8'h0f;
  localparam logic [7:0] ADDR_C1_LOW = 8'h10;
  localparam logic [7:0] ADDR_C1_CTRL = 8'h11;

  // Control register field positions.
  localparam int CTRL_MODE_LSB = 6;
  localparam int CTRL_RUN_BIT = 4;
  localparam int CTRL_EDGE_BIT = 3;

  // Control register value after pin and bus resets (warm reset keeps it): edge bit set, stopped.
  localparam logic [7:0] CTRL_RESET = 8'h08;

  // Counter widths and wrap values.
  localparam int CNT0_W = 8;
  localparam int CNT1_W = 16;
  localparam logic [15:0] CNT0_MAX = 16'h00ff;
  localparam logic [15:0] CNT1_MAX = 16'hffff;
  localparam logic [15:0] CNT_RESET = 16'h0000;

  // Internal time base: system clock divided by four.
  localparam int PRESCALE_DIV = 4;
  localparam logic [1:0] DIV_LAST = 2'(PRESCALE_DIV - 1);

  typedef enum logic [1:0] {
    MODE_UNUSED = 2'b00,
    MODE_EVENT = 2'b01,
    MODE_TIMER = 2'b10,
    MODE_PULSE = 2'b11
  } dtec_mode_t;

  typedef enum logic [1:0] {
    PW_ARM = 2'b00,
    PW_MEAS = 2'b01,
    PW_DONE = 2'b11
  } dtec_pw_t;

  typedef struct packed {
    dtec_mode_t mode;
    logic run_bit;
    logic edge_select;
  } dtec_ctrl_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } dtec_bus_t;

endpackage

`default_nettype wire

// ===== dtec_top.sv
// Dual count-up timer/event counter (8-bit and 16-bit) with register port.
`timescale 1ns/1ps
`default_nettype none

module dtec_top (
  // Clock and resets.
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic WARM_RST,
  input wire logic BUS_RST,
  // Register port.
  input wire dtec_pkg::dtec_bus_t BUS,
  output logic [7:0] RDATA,
  // Counter pins and interrupt enables.
  input wire logic [1:0] EVT_IN,
  input wire logic [1:0] IRQ_EN,
  // Events.
  output logic [1:0] OVF_PULSE,
  output logic [1:0] IRQ_REQ,
  output logic WAKEUP
);
  import dtec_pkg::*;

  function automatic logic [15:0] cnt_max(input int idx);
    return (idx == 0) ? CNT0_MAX : CNT1_MAX;
  endfunction

  function automatic logic [7:0] ctrl_read(input dtec_ctrl_t c);
    return {c.mode, 1'b0, c.run_bit, c.edge_select, 3'b000};
  endfunction

  logic [1:0] div_q;
  logic tick_q;
  logic [1:0] sync1_q;
  logic [1:0] sync2_q;
  logic [1:0] prev_q;
  logic [2:0] arm_q;
  logic [7:0] lowbuf_q;
  logic [7:0] rdata_q;
  logic [1:0] ovf_q;
  logic [1:0] irq_q;
  logic wake_q;
  dtec_ctrl_t ctrl_q [2];
  dtec_pw_t pw_q [2];
  logic [15:0] preload_q [2];
  logic [15:0] cnt_q [2];
  logic [15:0] pl_val [2];
  logic [1:0] pl_wr;
  logic [1:0] ctrl_wr;
  logic [1:0] hold;
  logic [1:0] rise;
  logic [1:0] fall;
  logic [1:0] edge_hit;
  logic [1:0] edge_back;
  logic [1:0] count_en;
  logic [1:0] wrap;
  logic [1:0] ovf;
  logic [1:0] pw_end;
  logic wr_c1_low;

  // Divide-by-four time base; warm reset only restarts its phase.
  always_ff @(posedge CLOCK) begin
    if (SRST || WARM_RST) begin
      div_q <= 2'h0;
      tick_q <= 1'b0;
    end else begin
      div_q <= div_q + 2'h1;
      tick_q <= (div_q == DIV_LAST);
    end
  end

  // Pin synchronisers and edge history.
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      sync1_q <= 2'h0;
      sync2_q <= 2'h0;
      prev_q <= 2'h0;
      arm_q <= 3'h0;
    end else begin
      sync1_q <= EVT_IN;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
      arm_q <= {arm_q[1:0], 1'b1};
    end
  end

  // A pin that rests high would otherwise look like a rising edge right after reset.
  assign rise = sync2_q & ~prev_q & {2{arm_q[2]}};
  assign fall = ~sync2_q & prev_q & {2{arm_q[2]}};

  // Register port decode.
  assign pl_wr[0] = BUS.wr && (BUS.addr == ADDR_C0_DATA);
  assign pl_wr[1] = BUS.wr && (BUS.addr == ADDR_C1_HIGH);
  assign ctrl_wr[0] = BUS.wr && (BUS.addr == ADDR_C0_CTRL);
  assign ctrl_wr[1] = BUS.wr && (BUS.addr == ADDR_C1_CTRL);
  assign wr_c1_low = BUS.wr && (BUS.addr == ADDR_C1_LOW);
  assign hold[0] = BUS.rd && (BUS.addr == ADDR_C0_DATA);
  assign hold[1] = BUS.rd && (BUS.addr == ADDR_C1_HIGH);
  assign pl_val[0] = {8'h00, BUS.wdata};
  assign pl_val[1] = {BUS.wdata, lowbuf_q};

  for (genvar g = 0; g < 2; g++) begin : g_cnt
    assign edge_hit[g] = ctrl_q[g].edge_select ? fall[g] : rise[g];
    assign edge_back[g] = ctrl_q[g].edge_select ? rise[g] : fall[g];
    assign wrap[g] = (cnt_q[g] == cnt_max(g));
    assign ovf[g] = count_en[g] && wrap[g];
    assign pw_end[g] = (pw_q[g] == PW_MEAS) && edge_back[g];

    always_comb begin
      count_en[g] = 1'b0;
      unique case (ctrl_q[g].mode)
        MODE_EVENT: count_en[g] = edge_hit[g];
        MODE_TIMER: count_en[g] = tick_q;
        MODE_PULSE: count_en[g] = tick_q && (pw_q[g] == PW_MEAS);
        MODE_UNUSED: count_en[g] = 1'b0;
      endcase
      count_en[g] = count_en[g] && ctrl_q[g].run_bit && !hold[g];
    end

    // Software write wins over the hardware clear of the run bit.
    always_ff @(posedge CLOCK) begin
      if (SRST || BUS_RST) begin
        ctrl_q[g] <= dtec_ctrl_t'({CTRL_RESET[7:6], CTRL_RESET[4:3]});
      end else if (ctrl_wr[g]) begin
        ctrl_q[g].mode <= dtec_mode_t'(BUS.wdata[CTRL_MODE_LSB +: 2]);
        ctrl_q[g].run_bit <= BUS.wdata[CTRL_RUN_BIT];
        ctrl_q[g].edge_select <= BUS.wdata[CTRL_EDGE_BIT];
      end else if (pw_end[g]) begin
        ctrl_q[g].run_bit <= 1'b0;
      end
    end

    // Pulse-width sequence; a control write re-arms it.
    always_ff @(posedge CLOCK) begin
      if (SRST || BUS_RST || ctrl_wr[g]) begin
        pw_q[g] <= PW_ARM;
      end else begin
        unique case (pw_q[g])
          PW_ARM: begin
            if (ctrl_q[g].mode == MODE_PULSE && ctrl_q[g].run_bit && edge_hit[g]) begin
              pw_q[g] <= PW_MEAS;
            end
          end
          PW_MEAS: begin
            if (edge_back[g]) begin
              pw_q[g] <= PW_DONE;
            end
          end
          PW_DONE: pw_q[g] <= PW_DONE;
        endcase
      end
    end

    always_ff @(posedge CLOCK) begin
      if (SRST) begin
        preload_q[g] <= CNT_RESET;
      end else if (pl_wr[g]) begin
        preload_q[g] <= pl_val[g];
      end
    end

    // Bus reset and warm reset keep the count.
    always_ff @(posedge CLOCK) begin
      if (SRST) begin
        cnt_q[g] <= CNT_RESET;
      end else if (pl_wr[g] && !ctrl_q[g].run_bit) begin
        cnt_q[g] <= pl_val[g];
      end else if (count_en[g]) begin
        cnt_q[g] <= wrap[g] ? preload_q[g] : cnt_q[g] + 16'h0001;
      end
    end
  end

  // Low-byte buffer.
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      lowbuf_q <= 8'h00;
    end else if (wr_c1_low) begin
      lowbuf_q <= BUS.wdata;
    end else if (hold[1]) begin
      lowbuf_q <= cnt_q[1][7:0];
    end
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge CLOCK) begin
    if (SRST || !BUS.rd) begin
      rdata_q <= 8'h00;
    end else begin
      unique case (BUS.addr)
        ADDR_C0_DATA: rdata_q <= cnt_q[0][7:0];
        ADDR_C0_CTRL: rdata_q <= ctrl_read(ctrl_q[0]);
        ADDR_C1_HIGH: rdata_q <= cnt_q[1][15:8];
        ADDR_C1_LOW: rdata_q <= lowbuf_q;
        ADDR_C1_CTRL: rdata_q <= ctrl_read(ctrl_q[1]);
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  // Overflow events; each is visible in the cycle the reload lands.
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      ovf_q <= 2'h0;
      irq_q <= 2'h0;
      wake_q <= 1'b0;
    end else begin
      ovf_q <= ovf;
      irq_q <= ovf & IRQ_EN;
      wake_q <= |ovf;
    end
  end

  assign RDATA = rdata_q;
  assign OVF_PULSE = ovf_q;
  assign IRQ_REQ = irq_q;
  assign WAKEUP = wake_q;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (SRST);

  sequence s_tick_gap;
    !tick_q [*3] ##1 tick_q;
  endsequence

  property p_prescale;
    disable iff (SRST || WARM_RST) tick_q |=> s_tick_gap;
  endproperty
  a_prescale: assert property (p_prescale) else $error("time base not one in four");

  property p_wrap_reload;
    count_en[0] && wrap[0] && !pl_wr[0] |=> cnt_q[0] == $past(preload_q[0]);
  endproperty
  a_wrap_reload: assert property (p_wrap_reload) else $error("counter zero reload wrong");

  property p_ovf_flag;
    count_en[1] && wrap[1] |=> OVF_PULSE[1] && cnt_q[1] == $past(preload_q[1]);
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not with reload");

  property p_stopped_load;
    pl_wr[0] && !ctrl_q[0].run_bit |=> cnt_q[0] == {8'h00, $past(BUS.wdata)};
  endproperty
  a_stopped_load: assert property (p_stopped_load) else $error("stopped preload not loaded");

  property p_high_write;
    pl_wr[1] |=> preload_q[1] == {$past(BUS.wdata), $past(lowbuf_q)};
  endproperty
  a_high_write: assert property (p_high_write) else $error("16-bit preload wrong");

  property p_high_read;
    hold[1] |=> RDATA == $past(cnt_q[1][15:8]) && lowbuf_q == $past(cnt_q[1][7:0])
      && cnt_q[1] == $past(cnt_q[1]);
  endproperty
  a_high_read: assert property (p_high_read) else $error("high read not consistent");

  property p_unused_idle;
    ctrl_q[1].mode == MODE_UNUSED && !pl_wr[1] |=> $stable(cnt_q[1]) && !OVF_PULSE[1];
  endproperty
  a_unused_idle: assert property (p_unused_idle) else $error("unused mode counted");

  sequence s_meas_end;
    pw_q[0] == PW_MEAS ##0 edge_back[0] ##0 !ctrl_wr[0] ##0 !BUS_RST;
  endsequence

  property p_meas_end;
    s_meas_end |=> !ctrl_q[0].run_bit && pw_q[0] == PW_DONE;
  endproperty
  a_meas_end: assert property (p_meas_end) else $error("measurement did not stop");

  property p_meas_hold;
    pw_q[0] == PW_DONE && !pl_wr[0] && !ctrl_wr[0] |=> $stable(cnt_q[0]);
  endproperty
  a_meas_hold: assert property (p_meas_hold) else $error("result not held");

  property p_run_sw_only;
    ctrl_q[1].mode != MODE_PULSE && !ctrl_wr[1] && !BUS_RST |=> $stable(ctrl_q[1].run_bit);
  endproperty
  a_run_sw_only: assert property (p_run_sw_only) else $error("run bit changed by hardware");

  property p_wake;
    ovf[0] || ovf[1] |=> WAKEUP;
  endproperty
  a_wake: assert property (p_wake) else $error("overflow gave no wake-up");

  property p_irq_mask;
    !IRQ_EN[0] |=> !IRQ_REQ[0];
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked overflow requested service");

  property p_low_write;
    wr_c1_low |=> $stable(preload_q[1]) && lowbuf_q == $past(BUS.wdata);
  endproperty
  a_low_write: assert property (p_low_write) else $error("low write touched preload");

  property p_event_edge;
    ctrl_q[1].mode == MODE_EVENT && !edge_hit[1] && !pl_wr[1] |=> $stable(cnt_q[1]);
  endproperty
  a_event_edge: assert property (p_event_edge) else $error("count without edge");

  property p_run_write;
    pl_wr[0] && ctrl_q[0].run_bit && !count_en[0]
      |=> $stable(cnt_q[0]) && preload_q[0] == {8'h00, $past(BUS.wdata)};
  endproperty
  a_run_write: assert property (p_run_write) else $error("preload write moved count");

  property p_read_hold;
    hold[0] |=> $stable(cnt_q[0]);
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("count moved in a read");

  property p_bus_reset;
    BUS_RST |=> ctrl_read(ctrl_q[0]) == CTRL_RESET && ctrl_read(ctrl_q[1]) == CTRL_RESET;
  endproperty
  a_bus_reset: assert property (p_bus_reset) else $error("control kept over bus reset");

  property p_warm_keep;
    WARM_RST && !BUS_RST && !ctrl_wr[1] && !pw_end[1] && !pl_wr[1]
      |=> $stable(ctrl_q[1]) && $stable(preload_q[1]);
  endproperty
  a_warm_keep: assert property (p_warm_keep) else $error("warm reset changed counter one");

endmodule // dtec_top

`default_nettype wire

// ===== dtec_pin_model.sv
// Behavioural model of the two external counter pins.
`timescale 1ns/1ps
`default_nettype none

module dtec_pin_model (
  // Clock.
  input wire logic clk,
  // Pin levels.
  output logic [1:0] pin
);
  // Pin zero rests low and pin one rests high, so each idles at its own level.
  initial begin
    pin = 2'b10;
  end

  // Moves one pin just after an edge and holds it for the given number of cycles.
  task automatic drive(input int idx, input logic lvl, input int hold);
    @(posedge clk);
    pin[idx] <= lvl;
    repeat (hold) @(posedge clk);
  endtask
endmodule // dtec_pin_model

`default_nettype wire

// ===== dtec_top_tb.sv
// Self-checking testbench of the dual timer/event counter.
`timescale 1ns/1ps
`default_nettype none

module dtec_top_tb;
  import dtec_pkg::*;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic warm_rst = 1'b0;
  logic bus_rst = 1'b0;
  dtec_bus_t bus = '0;
  logic [1:0] irq_en = 2'b00;
  logic [7:0] rdata;
  logic [1:0] evt_in;
  logic [1:0] ovf_pulse;
  logic [1:0] irq_req;
  logic wakeup;
  logic [7:0] held;
  int error_cnt = 0;
  int n_checks = 0;

  always #10 clock = ~clock;

  dtec_top dtec_top_i (
    .CLOCK(clock), .SRST(srst), .WARM_RST(warm_rst), .BUS_RST(bus_rst), .BUS(bus),
    .RDATA(rdata), .EVT_IN(evt_in), .IRQ_EN(irq_en), .OVF_PULSE(ovf_pulse),
    .IRQ_REQ(irq_req), .WAKEUP(wakeup)
  );
  dtec_pin_model dtec_pin_model_i (.clk(clock), .pin(evt_in));

  task automatic final_report;
    if (error_cnt == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rdv(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus.rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rdv(a, v);
    chk(16'(v), 16'(exp));
  endtask

  task automatic wait_ovf(input int idx, input int lim);
    logic seen;
    seen = 1'b0;
    repeat (lim) begin
      @(posedge clock);
      #1;
      if (ovf_pulse[idx] === 1'b1) begin
        seen = 1'b1;
        break;
      end
    end
    chk(16'(seen), 16'h0001);
  endtask

  task automatic t_reset;
    rd(ADDR_C0_CTRL, CTRL_RESET);
    rd(ADDR_C1_CTRL, CTRL_RESET);
    rd(ADDR_C0_DATA, 8'h00);
    rd(ADDR_C1_HIGH, 8'h00);
    wr(ADDR_C0_CTRL, 8'h37);
    rd(ADDR_C0_CTRL, 8'h10);
    repeat (24) @(posedge clock);
    rd(ADDR_C0_DATA, 8'h00);
    rd(8'h20, 8'h00);
  endtask

  task automatic t_pairing;
    wr(ADDR_C1_LOW, 8'h34);
    rd(ADDR_C1_LOW, 8'h34);
    wr(ADDR_C1_HIGH, 8'h12);
    wr(ADDR_C1_LOW, 8'h77);
    rd(ADDR_C1_HIGH, 8'h12);
    rd(ADDR_C1_LOW, 8'h34);
  endtask

  task automatic t_timer;
    wr(ADDR_C0_CTRL, 8'h00);
    wr(ADDR_C0_DATA, 8'hfe);
    rd(ADDR_C0_DATA, 8'hfe);
    @(posedge clock);
    irq_en <= 2'b01;
    wr(ADDR_C0_CTRL, 8'h90);
    wr(ADDR_C0_DATA, 8'h80);
    wait_ovf(0, 20);
    chk(16'(irq_req), 16'h0001);
    chk(16'(wakeup), 16'h0001);
    wr(ADDR_C0_CTRL, 8'h80);
    repeat (12) @(posedge clock);
    rd(ADDR_C0_DATA, 8'h80);
    wr(ADDR_C0_CTRL, 8'h90);
    rdv(ADDR_C0_DATA, held);
    rdv(ADDR_C0_DATA, held);
    @(posedge clock);
    rdv(ADDR_C0_DATA, held);
    rdv(ADDR_C0_DATA, held);
    chk(16'(held >= 8'h81 && held <= 8'h82), 16'h0001);
    wr(ADDR_C0_CTRL, 8'h80);
  endtask

  task automatic t_event;
    @(posedge clock);
    irq_en <= 2'b00;
    wr(ADDR_C1_LOW, 8'hfe);
    wr(ADDR_C1_HIGH, 8'hff);
    wr(ADDR_C1_CTRL, 8'h58);
    dtec_pin_model_i.drive(1, 1'b0, 8);
    dtec_pin_model_i.drive(1, 1'b1, 8);
    rd(ADDR_C1_HIGH, 8'hff);
    rd(ADDR_C1_LOW, 8'hff);
    dtec_pin_model_i.drive(1, 1'b0, 0);
    wait_ovf(1, 12);
    chk(16'(irq_req), 16'h0000);
    chk(16'(wakeup), 16'h0001);
    rd(ADDR_C1_CTRL, 8'h58);
    rd(ADDR_C1_HIGH, 8'hff);
    rd(ADDR_C1_LOW, 8'hfe);
  endtask

  task automatic t_pulse;
    logic [7:0] v;
    wr(ADDR_C0_CTRL, 8'h00);
    wr(ADDR_C0_DATA, 8'h00);
    wr(ADDR_C0_CTRL, 8'hd0);
    dtec_pin_model_i.drive(0, 1'b1, 40);
    dtec_pin_model_i.drive(0, 1'b0, 12);
    rd(ADDR_C0_CTRL, 8'hc0);
    rdv(ADDR_C0_DATA, held);
    chk(16'(held >= 8'd9 && held <= 8'd11), 16'h0001);
    dtec_pin_model_i.drive(0, 1'b1, 20);
    dtec_pin_model_i.drive(0, 1'b0, 12);
    rd(ADDR_C0_DATA, held);
    wr(ADDR_C0_CTRL, 8'hd0);
    dtec_pin_model_i.drive(0, 1'b1, 20);
    dtec_pin_model_i.drive(0, 1'b0, 12);
    rdv(ADDR_C0_DATA, v);
    chk(16'(v >= held + 8'd4 && v <= held + 8'd6), 16'h0001);
  endtask

  task automatic t_resets;
    @(posedge clock);
    warm_rst <= 1'b1;
    @(posedge clock);
    warm_rst <= 1'b0;
    rd(ADDR_C1_CTRL, 8'h58);
    rd(ADDR_C1_HIGH, 8'hff);
    rd(ADDR_C1_LOW, 8'hfe);
    @(posedge clock);
    bus_rst <= 1'b1;
    @(posedge clock);
    bus_rst <= 1'b0;
    rd(ADDR_C1_CTRL, CTRL_RESET);
    rd(ADDR_C1_HIGH, 8'hff);
    @(posedge clock);
    srst <= 1'b1;
    @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    rd(ADDR_C1_HIGH, 8'h00);
  endtask

  initial begin
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    t_reset();
    t_pairing();
    t_timer();
    t_event();
    t_pulse();
    t_resets();
    final_report();
  end

  // Cuts a hang short well past the few hundred cycles the tests need.
  initial begin
    repeat (5000) @(posedge clock);
    error_cnt++;
    final_report();
  end
endmodule // dtec_top_tb

`default_nettype wire
